// File: hw/fic_pkg.sv
// How it works
// R01: Indicator pin pulls low on a failure condition or on a host request.
// R02: Below the indicator supply threshold the pin stays released and cannot activate.
// R03: Off in init until the init time-out, on in fail-safe, held elsewhere; normal mode needs watchdog then release.
// R04: Init time-out expiring before init is left activates the indicator.
// R05: Normal mode watchdog failure activates: first in config 1/2, second in 3/4.
// R06: Restart mode reset-line short to supply or ground activates the indicator.
// R07: Host switch-on accepted only in normal mode, then held in every mode except init, which clears it.
// R08: A host-made activation is released only by a host release command or by entering init mode.
// R09: Failure activation released in normal after restart, watchdog trigger, then release.
// R10: Regulator below reset level with battery above supervision level too long is a time-out.
// R11: Reset and battery supervision levels each pick one of three settings.
// R12: Regulator time-out enters fail-safe and activates the indicator if supply allows.
// R13: Strap grounded starts development mode; open or high starts normal operation.
// R14: Strap pull-up enabled only during init mode.
// R15: Strap watched through init; development mode only if low for all of it.
// R16: Development mode stays latched until the device passes through off.
// R17: Both time-outs are parameterised counters on the device clock.
package fic_pkg;
  // ==========================================================
  // Timing
  // ==========================================================
  localparam int unsigned CLK_HZ            = 40_000_000;
  localparam int unsigned INIT_TIMEOUT_MS   = 256;
  localparam int unsigned REG_UV_TIMEOUT_MS = 1024;
  localparam int unsigned INIT_TIMEOUT_CYC  = INIT_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned REG_UV_CYC        = REG_UV_TIMEOUT_MS * (CLK_HZ / 1000);
  localparam int unsigned CNT_W             = 32;
  // ==========================================================
  // Modes and levels
  // ==========================================================
  typedef enum logic [2:0] {
    FIC_OFF, FIC_INIT, FIC_NORMAL, FIC_STOP, FIC_SLEEP, FIC_RESTART, FIC_FAILSAFE, FIC_FLASH
  } fic_mode_type;
  localparam logic [1:0] LEVEL_SEL_RST = 2'h0;
  localparam logic       DEV_MODE_RST  = 1'b0;
endpackage : fic_pkg

// File: hw/fic_tmo_if.sv
interface fic_tmo_if;
  logic run;
  logic expired;
  modport ctl (output run, input expired);
  modport cnt (input run, output expired);
endinterface : fic_tmo_if

// File: hw/fic_timer.sv
module fic_timer #(
  parameter int unsigned LIMIT = 100
) (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Control
  fic_tmo_if.cnt    tmo
);
  import fic_pkg::*;
  logic [CNT_W-1:0] cnt_r;
  wire              at_limit = (cnt_r >= CNT_W'(LIMIT));
  // Counter restarts whenever the condition drops, so only an unbroken run expires.
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (!tmo.run) begin
      cnt_r <= '0;
    end else if (!at_limit) begin
      cnt_r <= cnt_r + CNT_W'(1); // R17
    end
  end
  assign tmo.expired = tmo.run && at_limit;
endmodule : fic_timer

// File: hw/fic_sync.sv
module fic_sync (
  // Clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_b,
  // Data
  input  wire logic d,
  output logic      q
);
  logic s1_r;
  logic s2_r;
  logic s3_r;
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_r <= 1'b1;
      s2_r <= 1'b1;
      s3_r <= 1'b1;
      q    <= 1'b1;
    end else begin
      s1_r <= d;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        q <= s3_r;
      end
    end
  end
endmodule : fic_sync

// File: hw/fic_top.sv
module fic_top #(
  parameter int unsigned INIT_CYC = fic_pkg::INIT_TIMEOUT_CYC,
  parameter int unsigned UV_CYC   = fic_pkg::REG_UV_CYC
) (
  // Clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_b,
  // Device state
  input  wire fic_pkg::fic_mode_type mode,
  input  wire logic                  cfg_two_fail,
  input  wire logic                  init_exit,
  // Failure events
  input  wire logic                  wd_fail,
  input  wire logic                  wd_trigger_ok,
  input  wire logic                  rst_short_vcc,
  input  wire logic                  rst_short_gnd,
  input  wire logic                  thermal_sd,
  // Host commands
  input  wire logic                  spi_ind_on,
  input  wire logic                  spi_ind_off,
  // Analogue comparators
  input  wire logic                  supply_ok,
  input  wire logic [2:0]            reg_below_rt,
  input  wire logic [2:0]            batt_above_sth,
  input  wire logic [1:0]            level_sel,
  // Strap pin
  input  wire logic                  strap_in,
  output logic                       strap_pullup_en,
  // Indicator pin
  output logic                       ind_b_o,
  output logic                       ind_b_oe,
  // Status
  output logic                       uv_timeout,
  output logic                       fail_active,
  output logic                       spi_active,
  output logic                       software_dev_mode
);
  import fic_pkg::*;

  // ==========================================================
  // Input conditioning
  // ==========================================================
  logic strap_s;
  logic supply_s;
  logic uv_cond_s;
  logic uv_cond_raw;
  logic [1:0] sel;
  logic release_ok_r;
  logic wd_cnt_r;
  logic was_restart_r;
  logic strap_low_r;
  logic init_seen_r;
  logic fail_nxt;
  logic spi_nxt;
  fic_tmo_if init_tmo ();
  fic_tmo_if uv_tmo ();

  fic_sync u_strap (.ref_clk(ref_clk), .rst_b(rst_b), .d(strap_in), .q(strap_s));
  fic_sync u_supply (.ref_clk(ref_clk), .rst_b(rst_b), .d(supply_ok), .q(supply_s));
  fic_sync u_uv (.ref_clk(ref_clk), .rst_b(rst_b), .d(uv_cond_raw), .q(uv_cond_s));

  // A reserved level code falls back to the default level.
  assign sel         = (level_sel == 2'h3) ? LEVEL_SEL_RST : level_sel; // R11
  assign uv_cond_raw = reg_below_rt[sel] & batt_above_sth[sel]; // R10

  // ==========================================================
  // Time-outs
  // ==========================================================
  assign init_tmo.run = (mode == FIC_INIT);
  assign uv_tmo.run   = uv_cond_s;
  fic_timer #(.LIMIT(INIT_CYC)) u_init_tmr (.ref_clk(ref_clk), .rst_b(rst_b), .tmo(init_tmo.cnt));
  fic_timer #(.LIMIT(UV_CYC)) u_uv_tmr (.ref_clk(ref_clk), .rst_b(rst_b), .tmo(uv_tmo.cnt));
  assign uv_timeout = uv_tmo.expired; // R10 R12

  // ==========================================================
  // Failure activation
  // ==========================================================
  wire wd_hit   = (mode == FIC_NORMAL) && wd_fail && (!cfg_two_fail || wd_cnt_r); // R05
  wire rst_hit  = (mode == FIC_RESTART) && (rst_short_vcc || rst_short_gnd); // R06
  wire fail_set = init_tmo.expired || wd_hit || rst_hit || uv_tmo.expired ||
                  thermal_sd || (mode == FIC_FAILSAFE); // R04 R12 R03
  wire fail_clr = (mode == FIC_NORMAL) && release_ok_r && spi_ind_off; // R09
  wire spi_set  = (mode == FIC_NORMAL) && spi_ind_on; // R07
  wire spi_clr  = spi_ind_off; // R08

  // Set is listed last so outside init mode a clear in the same cycle never loses an event.
  assign fail_nxt = (mode == FIC_INIT) ? init_tmo.expired : ((fail_active && !fail_clr) || fail_set);
  assign spi_nxt  = (mode == FIC_INIT) ? 1'b0 : ((spi_active && !spi_clr) || spi_set); // R03

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      fail_active   <= 1'b0;
      spi_active    <= 1'b0;
      wd_cnt_r      <= 1'b0;
      was_restart_r <= 1'b0;
      release_ok_r  <= 1'b0;
    end else begin
      fail_active <= fail_nxt; // R01
      spi_active  <= spi_nxt; // R07
      if (mode != FIC_NORMAL) begin
        wd_cnt_r <= 1'b0;
      end else if (wd_fail) begin
        wd_cnt_r <= 1'b1;
      end
      if (mode == FIC_RESTART) begin
        was_restart_r <= 1'b1;
        release_ok_r  <= 1'b0;
      end else if (fail_clr) begin
        was_restart_r <= 1'b0;
        release_ok_r  <= 1'b0;
      end else if (mode == FIC_NORMAL && was_restart_r && wd_trigger_ok) begin
        release_ok_r <= 1'b1; // R09
      end
    end
  end

  // Open-drain: drive low only while active and the supply lets the stage work.
  assign ind_b_o  = 1'b0;
  assign ind_b_oe = (fail_active || spi_active) && supply_s; // R02 R01

  // ==========================================================
  // Development strap
  // ==========================================================
  assign strap_pullup_en = (mode == FIC_INIT); // R14

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strap_low_r       <= 1'b1;
      init_seen_r       <= 1'b0;
      software_dev_mode <= DEV_MODE_RST;
    end else if (mode == FIC_OFF) begin
      strap_low_r       <= 1'b1;
      init_seen_r       <= 1'b0;
      software_dev_mode <= DEV_MODE_RST; // R16
    end else if (mode == FIC_INIT && !init_seen_r) begin
      strap_low_r <= strap_low_r && !strap_s; // R15
      if (init_exit) begin
        init_seen_r       <= 1'b1;
        software_dev_mode <= strap_low_r && !strap_s; // R13
      end
    end
  end

  // ==========================================================
  // Checks
  // ==========================================================
  a_pin_needs_supply: assert property (@(posedge ref_clk) disable iff (!rst_b) // R02
    !supply_s |-> !ind_b_oe) else $error("indicator driven without supply");
  a_init_off: assert property (@(posedge ref_clk) disable iff (!rst_b) // R03
    (mode == FIC_INIT && !init_tmo.expired) |=> !spi_active) else $error("host flag in init");
  a_failsafe_on: assert property (@(posedge ref_clk) disable iff (!rst_b) // R03
    (mode == FIC_FAILSAFE) |=> fail_active) else $error("fail-safe without indicator");
  a_init_timeout: assert property (@(posedge ref_clk) disable iff (!rst_b) // R04
    init_tmo.expired |=> fail_active) else $error("init time-out missed");
  a_restart_short: assert property (@(posedge ref_clk) disable iff (!rst_b) // R06
    rst_hit |=> fail_active) else $error("reset short missed");
  a_spi_on_normal: assert property (@(posedge ref_clk) disable iff (!rst_b) // R07
    (!spi_active && mode != FIC_NORMAL && mode != FIC_INIT) |=> !spi_active) else $error("host on outside normal");
  a_spi_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // R08
    (spi_active && !spi_ind_off && mode != FIC_INIT) |=> spi_active) else $error("host flag lost");
  a_fail_hold: assert property (@(posedge ref_clk) disable iff (!rst_b) // R09
    (fail_active && !(mode == FIC_NORMAL && release_ok_r)) |=> fail_active) else $error("early release");
  // A release only counts once restart and a good watchdog trigger have armed it.
  sequence s_release_armed;
    (mode == FIC_NORMAL) && release_ok_r;
  endsequence
  a_fail_release: assert property (@(posedge ref_clk) disable iff (!rst_b) // R09
    (s_release_armed ##0 (spi_ind_off && !fail_set)) |=> !fail_active) else $error("release ignored");
  a_wd_second: assert property (@(posedge ref_clk) disable iff (!rst_b) // R05
    (mode == FIC_NORMAL && wd_fail && cfg_two_fail && wd_cnt_r) |=> fail_active)
    else $error("second watchdog fail missed");
  a_spi_release: assert property (@(posedge ref_clk) disable iff (!rst_b) // R08
    (spi_ind_off && !spi_set) |=> !spi_active) else $error("host release ignored");
  a_wd_first: assert property (@(posedge ref_clk) disable iff (!rst_b) // R05
    (mode == FIC_NORMAL && wd_fail && !cfg_two_fail) |=> fail_active) else $error("watchdog fail missed");
  a_uv_timeout: assert property (@(posedge ref_clk) disable iff (!rst_b) // R12
    uv_timeout |=> fail_active) else $error("uv time-out missed");
  a_pullup_init: assert property (@(posedge ref_clk) disable iff (!rst_b) // R14
    strap_pullup_en == (mode == FIC_INIT)) else $error("pull-up outside init");
  a_dev_latch: assert property (@(posedge ref_clk) disable iff (!rst_b) // R16
    (mode != FIC_OFF && !(mode == FIC_INIT && init_exit)) |=> $stable(software_dev_mode))
    else $error("dev mode changed");
endmodule : fic_top

// File: verif/fic_far_side.sv
module fic_far_side (
  // Clock
  input  wire logic ref_clk,
  // Pins seen from outside
  input  wire logic ind_b_o,
  input  wire logic ind_b_oe,
  input  wire logic strap_pullup_en,
  input  wire logic strap_gnd,
  output logic      ind_wire,
  output logic      strap_in
);
  timeunit 1ns;
  timeprecision 1ps;
  logic float_r;
  // ==========================================================
  // Pin resolution
  // ==========================================================
  // An open strap with the pull-up off floats, so it wanders instead of holding a level.
  always @(posedge ref_clk) float_r <= ~float_r;
  initial float_r = 1'b0;
  assign ind_wire = ind_b_oe ? ind_b_o : 1'b1;
  assign strap_in = strap_gnd ? 1'b0 : (strap_pullup_en ? 1'b1 : float_r);
endmodule : fic_far_side

// File: verif/tb_top.sv
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import fic_pkg::*;
  localparam int INIT_N = 20;
  localparam int UV_N = 30;
  localparam int P_ON = 0, P_OFF = 1, P_WDF = 2, P_WDT = 3, P_IEX = 4;
  logic ref_clk = 0, rst_b = 0, cfg_two_fail = 0, init_exit = 0, wd_fail = 0, wd_trigger_ok = 0;
  logic rst_short_vcc = 0, rst_short_gnd = 0, thermal_sd = 0, spi_ind_on = 0, spi_ind_off = 0;
  logic supply_ok = 1, strap_gnd = 1;
  logic [2:0] reg_below_rt = 3'h0, batt_above_sth = 3'h0;
  logic [1:0] level_sel = 2'h0;
  fic_mode_type mode = FIC_OFF;
  wire strap_in, strap_pullup_en, ind_b_o, ind_b_oe, ind_wire;
  wire uv_timeout, fail_active, spi_active, software_dev_mode;
  int bad_count = 0, samples_checked = 0;
  always #12.5 ref_clk = ~ref_clk;
  fic_top #(.INIT_CYC(INIT_N), .UV_CYC(UV_N)) i_fic_top (.ref_clk(ref_clk), .rst_b(rst_b), .mode(mode),
    .cfg_two_fail(cfg_two_fail), .init_exit(init_exit), .wd_fail(wd_fail), .wd_trigger_ok(wd_trigger_ok),
    .rst_short_vcc(rst_short_vcc), .rst_short_gnd(rst_short_gnd), .thermal_sd(thermal_sd),
    .spi_ind_on(spi_ind_on), .spi_ind_off(spi_ind_off), .supply_ok(supply_ok), .reg_below_rt(reg_below_rt),
    .batt_above_sth(batt_above_sth), .level_sel(level_sel), .strap_in(strap_in),
    .strap_pullup_en(strap_pullup_en), .ind_b_o(ind_b_o), .ind_b_oe(ind_b_oe), .uv_timeout(uv_timeout),
    .fail_active(fail_active), .spi_active(spi_active), .software_dev_mode(software_dev_mode));
  fic_far_side i_fic_far_side (.ref_clk(ref_clk), .ind_b_o(ind_b_o), .ind_b_oe(ind_b_oe),
    .strap_pullup_en(strap_pullup_en), .strap_gnd(strap_gnd), .ind_wire(ind_wire), .strap_in(strap_in));
  // ==========================================================
  // Tasks
  // ==========================================================
  task results;
    $display("Checks %0d, mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : results
  task chk(input logic got, input logic exp, input string what);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] %0t %s", $time, what);
    end
  endtask : chk
  task tick(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : tick
  // Commands are one-cycle pulses with a quiet cycle after, so a repeated pulse is a fresh edge.
  task pls(input int k);
    case (k)
      P_ON:    spi_ind_on = 1'b1;
      P_OFF:   spi_ind_off = 1'b1;
      P_WDF:   wd_fail = 1'b1;
      P_WDT:   wd_trigger_ok = 1'b1;
      default: init_exit = 1'b1;
    endcase
    tick(1);
    {spi_ind_on, spi_ind_off, wd_fail, wd_trigger_ok, init_exit} = 5'h00;
    tick(1);
  endtask : pls
  task wait_fail(input int n);
    for (int i = 0; i < n && fail_active !== 1'b1; i++) tick(1);
    if (fail_active !== 1'b1) begin
      bad_count++;
      $display("[FAIL] %0t wait ran out", $time);
      results();
    end
  endtask : wait_fail
  task release_fail;
    mode = FIC_RESTART;
    tick(2);
    mode = FIC_NORMAL;
    tick(1);
    pls(P_OFF);
    chk(fail_active, 1'b1, "released before trigger");
    pls(P_WDT);
    chk(fail_active, 1'b1, "released by trigger");
    pls(P_OFF);
    chk(fail_active, 1'b0, "not released");
  endtask : release_fail
  // ==========================================================
  // Sequence
  // ==========================================================
  initial begin
    tick(2);
    rst_b = 1'b1;
    chk(ind_b_oe, 1'b0, "pin driven after reset");
    chk(strap_pullup_en, 1'b0, "pull-up on in off");
    tick(5);
    mode = FIC_INIT;
    tick(1);
    chk(strap_pullup_en, 1'b1, "pull-up off in init");
    tick(8);
    pls(P_IEX);
    mode = FIC_NORMAL;
    tick(1);
    chk(software_dev_mode, 1'b0 ^ 1'b1, "dev mode missing");
    chk(fail_active, 1'b0, "early init fail");
    chk(strap_pullup_en, 1'b0, "pull-up on in normal");
    pls(P_ON);
    chk(spi_active, 1'b1, "host on ignored");
    chk(ind_wire, 1'b0, "pin not low");
    mode = FIC_STOP;
    tick(2);
    chk(spi_active, 1'b1, "host on lost");
    pls(P_OFF);
    chk(spi_active, 1'b0, "host off ignored");
    pls(P_ON);
    chk(spi_active, 1'b0, "host on outside normal");
    chk(ind_wire, 1'b1, "pin not released");
    mode = FIC_NORMAL;
    cfg_two_fail = 1'b1;
    pls(P_WDF);
    chk(fail_active, 1'b0, "first failure counted");
    pls(P_WDF);
    chk(fail_active, 1'b1, "second failure missed");
    pls(P_WDT);
    pls(P_OFF);
    chk(fail_active, 1'b1, "released without restart");
    release_fail();
    cfg_two_fail = 1'b0;
    pls(P_WDF);
    chk(fail_active, 1'b1, "first failure missed");
    release_fail();
    for (int i = 0; i < 2; i++) begin
      mode = FIC_RESTART;
      {rst_short_vcc, rst_short_gnd} = (i == 0) ? 2'h2 : 2'h1;
      tick(2);
      chk(fail_active, 1'b1, "reset short missed");
      {rst_short_vcc, rst_short_gnd} = 2'h0;
      release_fail();
    end
    mode = FIC_SLEEP;
    thermal_sd = 1'b1;
    tick(2);
    thermal_sd = 1'b0;
    chk(fail_active, 1'b1, "thermal missed");
    release_fail();
    mode = FIC_RESTART;
    level_sel = 2'h1;
    reg_below_rt = 3'h2;
    tick(UV_N + 10);
    chk(uv_timeout, 1'b0, "time-out without battery");
    level_sel = 2'h0;
    batt_above_sth = 3'h2;
    tick(UV_N + 10);
    chk(uv_timeout, 1'b0, "wrong level used");
    level_sel = 2'h1;
    tick(UV_N - 5);
    chk(uv_timeout, 1'b0, "time-out too early");
    wait_fail(20);
    chk(uv_timeout, 1'b1, "time-out missed");
    mode = FIC_FAILSAFE;
    {reg_below_rt, batt_above_sth} = 6'h00;
    tick(2);
    chk(fail_active, 1'b1, "fail-safe not on");
    supply_ok = 1'b0;
    tick(6);
    chk(ind_wire, 1'b1, "pin low on low supply");
    supply_ok = 1'b1;
    tick(6);
    chk(ind_b_oe, 1'b1, "pin not restored");
    chk(software_dev_mode, 1'b1, "dev mode lost");
    mode = FIC_OFF;
    tick(2);
    chk(software_dev_mode, 1'b0, "dev mode kept in off");
    strap_gnd = 1'b0;
    rst_b = 1'b0;
    tick(2);
    rst_b = 1'b1;
    mode = FIC_INIT;
    tick(INIT_N - 5);
    chk(ind_b_oe, 1'b0, "init time-out early");
    wait_fail(20);
    chk(ind_b_oe, 1'b1, "init time-out pin");
    pls(P_IEX);
    mode = FIC_NORMAL;
    tick(1);
    chk(software_dev_mode, 1'b0, "dev mode with open strap");
    results();
  end
endmodule : tb_top
